// ---- lts_pkg.sv ----
// package for the leak test auto sequencer: register map, fields, types
`default_nettype none
package lts_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SP_EN = 4'h1;
  localparam logic [3:0] REG_SP0 = 4'h2;
  localparam logic [3:0] REG_SP1 = 4'h3;
  localparam logic [3:0] REG_SP2 = 4'h4;
  localparam logic [3:0] REG_SP3 = 4'h5;
  localparam logic [3:0] REG_ROUGH_T = 4'h6;
  localparam logic [3:0] REG_TEST_T = 4'h7;
  localparam logic [3:0] REG_XFER_COARSE = 4'h8;
  localparam logic [3:0] REG_XFER_FINE = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'ha;
  localparam logic [3:0] REG_IRQ_STAT = 4'hb;
  localparam logic [3:0] REG_IRQ_MASK = 4'hc;
  localparam logic [3:0] REG_RESULT = 4'hd;
  localparam int CTRL_AUTO_ON = 0;
  localparam int CTRL_ALLOW_PRECISE = 1;
  localparam int CTRL_OUT_MODE_LSB = 2;
  localparam int IRQ_PASS = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_REFUSED = 3;
  localparam logic [15:0] XFER_COARSE_LIMIT = 16'h0a00;
  localparam logic [15:0] XFER_FINE_LIMIT = 16'h0120;
  localparam logic [15:0] XFER_COARSE_RST = 16'h0900;
  localparam logic [15:0] XFER_FINE_RST = 16'h0100;
  localparam logic [15:0] ROUGH_T_RST = 16'h000a;
  localparam logic [15:0] TEST_T_RST = 16'h0005;
  localparam logic [11:0] SP_RST = 12'hfff;
  localparam int TICK_NS = 100_000_000;
  localparam int CLK_NS = 100;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int BAR_SEGS = 50;
  localparam int MANT_FULL = 100;
  localparam logic [15:0] LOG2_STEP = 16'h0800;
  localparam logic [15:0] LOG3_STEP = 16'h0c00;
  localparam logic [15:0] TONE_BASE = 16'h1000;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_START = 3'b001,
    PH_ROUGH = 3'b010,
    PH_COARSE = 3'b011,
    PH_PRECISE = 3'b100,
    PH_VENT = 3'b101,
    PH_HOLD = 3'b110
  } lts_phase_t;
  typedef enum logic [1:0] {
    OUT_LIN = 2'b00,
    OUT_LOG2 = 2'b01,
    OUT_LOG3 = 2'b10
  } lts_out_mode_t;
  // leak rate: mantissa 0..99 tenths, signed decade exponent
  typedef struct packed {
    logic signed [4:0] expo;
    logic [6:0] mant;
  } lts_rate_t;
  typedef struct packed {
    logic start;
    logic vent;
    logic other;
  } lts_btn_t;
endpackage
`default_nettype wire

// ---- lts_plant.sv ----
// gauge and leak-rate model on the far side of the sequencer
`default_nettype none
module lts_plant
  import lts_pkg::*;
(
  input wire logic i_clk, // clock
  input wire lts_pkg::lts_phase_t i_phase, // sequencer phase
  input wire logic i_slow, // pump stalls
  input wire lts_pkg::lts_rate_t i_leak, // commanded rate
  output lts_pkg::lts_rate_t o_rate, // measured rate
  output logic [15:0] o_press // test pressure
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_rate = i_leak;
  // pumps only within a cycle; a stalled pump never reaches transfer
  always_ff @(posedge i_clk)
  begin
    if (i_phase inside {PH_ROUGH, PH_COARSE, PH_PRECISE})
    begin
      if (!i_slow && o_press >= 16'h0200)
        o_press <= o_press - 16'h0200;
    end
    else
      o_press <= 16'h7000;
  end
endmodule
`default_nettype wire

// ---- lts_seq.sv ----
// leak test auto sequencer: phases, set points, displays, analog and tone
//
// Contract
// RULE1 four limit set points, each acts only while its enable bit is set
// RULE2 limit alarm whenever measured rate exceeds the active set point
// RULE3 with several enabled, the lowest enabled limit decides
// RULE4 50-segment bar follows mantissa 0..10; exponent shown separately
// RULE5 analog output linear, or log at 2 V or 3 V per decade
// RULE6 tone frequency rises monotonically with leak rate
// RULE7 auto cycle runs start, rough, test, vent; times programmable
// RULE8 pass at cycle end returns to vent
// RULE9 fail shows reject, drives set point output, holds; only vent accepted
// RULE10 rate at cycle end is latched, shown and held until next start
// RULE11 rough moves to test as soon as transfer pressure is reached
// RULE12 rough time elapsed without transfer pressure aborts into hold
// RULE13 test lasts the full test time, then the limit compare
// RULE14 normal mode tests coarse first, precise only if no coarse leak
// RULE15 precise transfer off keeps testing coarse, never precise
// RULE16 transfer settings above fixed upper limits are refused
// RULE17 coarse test entered when pressure crosses the coarse set point
// RULE18 set point states readable by host and pendant
// RULE19 rates compared exponent first, then mantissa
`default_nettype none
module lts_seq
  import lts_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic I_MCLK, // system clock
  input wire logic I_RESETN, // synchronous reset, active low
  input wire logic I_CE, // clock enable
  input wire logic [3:0] I_ADDR, // register index
  input wire logic [15:0] I_WDATA, // write data
  input wire logic I_WR, // write strobe
  input wire logic I_RD, // read strobe
  output logic [15:0] O_RDATA, // read data, cycle after read strobe
  input wire lts_pkg::lts_btn_t I_BTN, // operator button pulses
  input wire lts_pkg::lts_rate_t I_RATE, // measured leak rate
  input wire logic [15:0] I_PRESS, // test pressure, larger is higher
  output lts_pkg::lts_phase_t O_PHASE, // current phase
  output logic O_REJECT, // reject indication
  output logic O_SP_OUT, // limit set point output
  output logic O_ALARM, // live limit alarm
  output logic [3:0] O_SP_STATE, // per set point exceed state
  output logic [49:0] O_BAR, // bar graph segments
  output logic signed [4:0] O_EXPO, // exponent display
  output logic [15:0] O_ANALOG, // analog output code
  output logic [15:0] O_TONE, // tone frequency code
  output logic O_IRQ // interrupt, level
);
  typedef struct packed {
    lts_phase_t phase;
    logic [15:0] ctrl;
    logic [3:0] sp_en;
    logic [3:0][11:0] sp;
    logic [15:0] rough_t;
    logic [15:0] test_t;
    logic [15:0] xfer_c;
    logic [15:0] xfer_f;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] presc;
    logic [15:0] secs;
    logic reject;
    logic held;
    lts_rate_t latched;
    logic [15:0] rdata;
  } lts_state_t;

  lts_state_t r, next_r;
  logic [3:0] sp_over;
  logic [3:0] sp_cand;
  logic [11:0] lim;
  logic lim_any;
  logic over_lim;
  logic tick;
  lts_rate_t shown;
  logic [15:0] rd_mux;
  logic [3:0] ev;

  function automatic logic rate_gt(input lts_rate_t a, input lts_rate_t b);
    if (a.expo != b.expo)
      return a.expo > b.expo; // RULE19
    return a.mant > b.mant;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sp
      assign sp_cand[gi] = r.sp_en[gi]; // RULE1
      assign sp_over[gi] = r.sp_en[gi] && rate_gt(I_RATE, lts_rate_t'(r.sp[gi])); // RULE18
    end
  endgenerate

  // lowest enabled limit wins
  always_comb
  begin
    lim = SP_RST;
    lim_any = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      if (sp_cand[k] && (!lim_any || rate_gt(lts_rate_t'(lim), lts_rate_t'(r.sp[k]))))
      begin
        lim = r.sp[k]; // RULE3
        lim_any = 1'b1;
      end
    end
  end

  assign over_lim = lim_any && rate_gt(I_RATE, lts_rate_t'(lim)); // RULE2
  assign tick = (r.presc == 32'(TICK_CYCLES - 1));

  always_comb
  begin
    unique case (I_ADDR)
      REG_CTRL: rd_mux = r.ctrl;
      REG_SP_EN: rd_mux = {12'h000, r.sp_en};
      REG_SP0: rd_mux = {4'h0, r.sp[0]};
      REG_SP1: rd_mux = {4'h0, r.sp[1]};
      REG_SP2: rd_mux = {4'h0, r.sp[2]};
      REG_SP3: rd_mux = {4'h0, r.sp[3]};
      REG_ROUGH_T: rd_mux = r.rough_t;
      REG_TEST_T: rd_mux = r.test_t;
      REG_XFER_COARSE: rd_mux = r.xfer_c;
      REG_XFER_FINE: rd_mux = r.xfer_f;
      REG_STATUS: rd_mux = {4'h0, sp_over, over_lim, r.reject, r.held, 2'h0, r.phase}; // RULE18
      REG_IRQ_STAT: rd_mux = {12'h000, r.irq_stat};
      REG_IRQ_MASK: rd_mux = {12'h000, r.irq_mask};
      REG_RESULT: rd_mux = {4'h0, r.latched};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_comb
  begin
    next_r = r;
    ev = 4'h0;
    next_r.rdata = I_RD ? rd_mux : 16'h0000;
    next_r.presc = tick ? 32'h0 : r.presc + 32'h1;
    if (tick && r.secs != 16'hffff)
      next_r.secs = r.secs + 16'h1;
    if (I_WR)
    begin
      unique case (I_ADDR)
        REG_CTRL: next_r.ctrl = I_WDATA;
        REG_SP_EN: next_r.sp_en = I_WDATA[3:0]; // RULE1
        REG_SP0: next_r.sp[0] = I_WDATA[11:0];
        REG_SP1: next_r.sp[1] = I_WDATA[11:0];
        REG_SP2: next_r.sp[2] = I_WDATA[11:0];
        REG_SP3: next_r.sp[3] = I_WDATA[11:0];
        REG_ROUGH_T: next_r.rough_t = I_WDATA;
        REG_TEST_T: next_r.test_t = I_WDATA;
        REG_XFER_COARSE:
          if (I_WDATA <= XFER_COARSE_LIMIT)
            next_r.xfer_c = I_WDATA;
          else
            ev[IRQ_REFUSED] = 1'b1; // RULE16
        REG_XFER_FINE:
          if (I_WDATA <= XFER_FINE_LIMIT)
            next_r.xfer_f = I_WDATA;
          else
            ev[IRQ_REFUSED] = 1'b1; // RULE16
        REG_IRQ_MASK: next_r.irq_mask = I_WDATA[3:0];
        default: ;
      endcase
    end
    // hold after a fail: only vent is honoured
    if (I_BTN.vent)
    begin
      next_r.phase = PH_VENT;
      next_r.held = 1'b0;
    end
    else if (I_BTN.start && !r.held && r.ctrl[CTRL_AUTO_ON]) // RULE9
    begin
      next_r.phase = PH_START; // RULE7
      next_r.reject = 1'b0; // RULE10
      next_r.secs = 16'h0;
      next_r.presc = 32'h0;
    end
    else
    begin
      unique case (r.phase)
        PH_IDLE, PH_VENT, PH_HOLD: ;
        PH_START:
        begin
          next_r.phase = PH_ROUGH; // RULE7
          next_r.secs = 16'h0;
          next_r.presc = 32'h0;
        end
        PH_ROUGH:
          if (I_PRESS <= r.xfer_c)
          begin
            next_r.phase = PH_COARSE; // RULE11 RULE17
            next_r.secs = 16'h0;
            next_r.presc = 32'h0;
          end
          else if (r.secs >= r.rough_t)
          begin
            next_r.phase = PH_HOLD; // RULE12
            next_r.held = 1'b1;
            ev[IRQ_ABORT] = 1'b1;
          end
        PH_COARSE, PH_PRECISE:
          // a coarse leak only blocks the precise step; the verdict still waits out the test time
          if (r.secs >= r.test_t) // RULE13
            next_r = end_cycle(next_r, over_lim, I_RATE, ev, ev);
          else if (r.phase == PH_COARSE && !over_lim && r.ctrl[CTRL_ALLOW_PRECISE] // RULE14
                   && I_PRESS <= r.xfer_f) // RULE15
          begin
            next_r.phase = PH_PRECISE; // RULE14
          end
        default: next_r.phase = PH_IDLE;
      endcase
    end
    next_r.irq_stat = r.irq_stat | ev;
    if (I_RD && I_ADDR == REG_IRQ_STAT)
      next_r.irq_stat = ev;
  end

  function automatic lts_state_t end_cycle(input lts_state_t s, input logic fail, input lts_rate_t rt,
                                           input logic [3:0] ei, output logic [3:0] eo);
    lts_state_t t;
    t = s;
    eo = ei;
    t.latched = rt; // RULE10
    if (fail)
    begin
      t.phase = PH_HOLD; // RULE9
      t.reject = 1'b1;
      t.held = 1'b1;
      eo[IRQ_FAIL] = 1'b1;
    end
    else
    begin
      t.phase = PH_VENT; // RULE8
      eo[IRQ_PASS] = 1'b1;
    end
    return t;
  endfunction

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RESETN)
    begin
      r <= '0;
      r.phase <= PH_IDLE;
      r.rough_t <= ROUGH_T_RST;
      r.test_t <= TEST_T_RST;
      r.xfer_c <= XFER_COARSE_RST;
      r.xfer_f <= XFER_FINE_RST;
      r.sp <= {4{SP_RST}};
      r.ctrl <= 16'h0002;
    end
    else if (I_CE)
      r <= next_r;
  end

  // show latched result between cycles, live rate while running
  assign shown = (r.phase == PH_VENT || r.phase == PH_HOLD || r.phase == PH_IDLE)
                 && (r.reject || r.latched != '0) ? r.latched : I_RATE; // RULE10

  generate
    for (gi = 0; gi < BAR_SEGS; gi++)
    begin : g_bar
      assign O_BAR[gi] = (32'(shown.mant) * BAR_SEGS) > (gi * MANT_FULL); // RULE4
    end
  endgenerate

  always_comb
  begin
    logic [15:0] dec;
    dec = 16'(signed'(shown.expo) + 16);
    unique case (lts_out_mode_t'(r.ctrl[CTRL_OUT_MODE_LSB +: 2])) // RULE5
      // top decades wrap in the 3 V log mode only; real leak rates sit far below them
      OUT_LOG2: O_ANALOG = 16'(dec * LOG2_STEP) + 16'(shown.mant * 20);
      OUT_LOG3: O_ANALOG = 16'(dec * LOG3_STEP) + 16'(shown.mant * 30);
      default: O_ANALOG = {9'h000, shown.mant};
    endcase
  end

  assign O_TONE = TONE_BASE + 16'({dec_of(I_RATE), I_RATE.mant} * 4); // RULE6

  function automatic logic [4:0] dec_of(input lts_rate_t a);
    // offset binary keeps the order of signed exponents
    return {~a.expo[4], a.expo[3:0]};
  endfunction

  assign O_PHASE = r.phase;
  assign O_REJECT = r.reject; // RULE9
  assign O_SP_OUT = r.reject; // RULE9
  assign O_ALARM = over_lim; // RULE2
  assign O_SP_STATE = sp_over; // RULE18
  assign O_EXPO = shown.expo; // RULE4
  assign O_RDATA = r.rdata;
  assign O_IRQ = |(r.irq_stat & r.irq_mask);
endmodule
`default_nettype wire

// ---- lts_seq_checker.sv ----
// port assertions for the leak test auto sequencer
`default_nettype none
module lts_seq_checker
  import lts_pkg::*;
(
  input wire logic I_MCLK, // clock
  input wire logic I_RESETN, // reset, low
  input wire logic I_CE, // enable
  input wire lts_pkg::lts_btn_t I_BTN, // buttons
  input wire lts_pkg::lts_rate_t I_RATE, // rate
  input wire logic [15:0] I_PRESS, // pressure
  input wire lts_pkg::lts_phase_t O_PHASE, // phase
  input wire logic O_REJECT, // reject
  input wire logic O_SP_OUT, // set point out
  input wire logic O_ALARM, // alarm
  input wire logic [3:0] O_SP_STATE, // exceed states
  input wire logic [49:0] O_BAR, // bar
  input wire logic [15:0] O_TONE // tone
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RESETN);
  property p_start; O_PHASE == PH_START && I_CE && !I_BTN.vent |=> O_PHASE == PH_ROUGH; endproperty
  a_start: assert property (p_start) else $error("start not followed by rough");
  // valid only while software never sets the coarse point below its reset value
  property p_xfer; O_PHASE == PH_ROUGH && I_CE && !I_BTN.vent && I_PRESS <= XFER_COARSE_RST |=> O_PHASE == PH_COARSE; endproperty
  a_xfer: assert property (p_xfer) else $error("no coarse entry at transfer");
  property p_alarm; O_ALARM == |O_SP_STATE; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm and set point states disagree");
  property p_bar; ((O_BAR + 50'h1) & O_BAR) == 50'h0; endproperty
  a_bar: assert property (p_bar) else $error("bar not a solid run");
  property p_tone; $stable(I_RATE.expo) && I_RATE.mant > $past(I_RATE.mant) |-> O_TONE >= $past(O_TONE); endproperty
  a_tone: assert property (p_tone) else $error("tone fell with rising rate");
  property p_hold; O_PHASE == PH_HOLD && !I_BTN.vent |=> O_PHASE == PH_HOLD; endproperty
  a_hold: assert property (p_hold) else $error("hold left without vent");
  property p_vent; I_CE && I_BTN.vent |=> O_PHASE == PH_VENT; endproperty
  a_vent: assert property (p_vent) else $error("vent button ignored");
  property p_reject; $rose(O_REJECT) |-> O_SP_OUT && O_PHASE == PH_HOLD; endproperty
  a_reject: assert property (p_reject) else $error("reject without set point output and hold");
  c_pass: cover property (O_PHASE == PH_COARSE ##1 O_PHASE == PH_VENT);
  c_precise: cover property (O_PHASE == PH_PRECISE);
  c_fail: cover property ($rose(O_REJECT));
endmodule
bind lts_seq lts_seq_checker lts_seq_checker_inst (.I_MCLK, .I_RESETN, .I_CE, .I_BTN, .I_RATE, .I_PRESS,
  .O_PHASE, .O_REJECT, .O_SP_OUT, .O_ALARM, .O_SP_STATE, .O_BAR, .O_TONE);
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the leak test auto sequencer
`default_nettype none
module tb
  import lts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {lts_rate_t r; logic [3:0] en; logic a; logic [3:0] s;} lts_row_t;
  localparam int TICKS = 10;
  logic mclk = 0, resetn = 0, wr = 0, rd = 0, slow = 0, seen = 0, ce = 1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata, press, analog, ana0, tone, tone0;
  logic [3:0] sp_state;
  lts_btn_t btn = '0;
  lts_rate_t leak = '0, rate;
  lts_phase_t phase;
  logic reject, sp_out, alarm, irq;
  logic [49:0] bar;
  logic signed [4:0] expo;
  int errors = 0, checks_done = 0, n;
  lts_row_t rows [7] = '{'{'{-5'sd6, 7'd40}, 4'h1, 1'b0, 4'h0}, '{'{-5'sd6, 7'd60}, 4'h1, 1'b1, 4'h1},
    '{'{-5'sd7, 7'd90}, 4'h1, 1'b0, 4'h0}, '{'{-5'sd6, 7'd40}, 4'h3, 1'b1, 4'h2},
    '{'{-5'sd6, 7'd99}, 4'h0, 1'b0, 4'h0}, '{'{-5'sd7, 7'd0}, 4'h2, 1'b0, 4'h0},
    '{'{-5'sd7, 7'd30}, 4'h2, 1'b1, 4'h2}};
  lts_seq #(.TICK_CYCLES(TICKS)) lts_seq_inst (.I_MCLK(mclk), .I_RESETN(resetn), .I_CE(ce), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_BTN(btn), .I_RATE(rate), .I_PRESS(press),
    .O_PHASE(phase), .O_REJECT(reject), .O_SP_OUT(sp_out), .O_ALARM(alarm), .O_SP_STATE(sp_state), .O_BAR(bar),
    .O_EXPO(expo), .O_ANALOG(analog), .O_TONE(tone), .O_IRQ(irq));
  lts_plant lts_plant_inst (.i_clk(mclk), .i_phase(phase), .i_slow(slow), .i_leak(leak), .o_rate(rate),
    .o_press(press));
  initial forever #50 mclk = ~mclk;
  task automatic chk(input string what, input logic [49:0] got, input logic [49:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic done(input string s);
    $display("%s finished, errors %0d", s, errors);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask
  task automatic push(input lts_btn_t b);
    @(posedge mclk);
    btn <= b;
    @(posedge mclk);
    btn <= '0;
  endtask
  // every wait is bounded; running out ends the run as a failure
  task automatic wait_ph(input lts_phase_t ph, input int lim);
    n = 0;
    while (phase !== ph && n < lim)
    begin
      @(posedge mclk);
      #1;
      n++;
      if (phase === PH_PRECISE)
        seen = 1;
    end
    if (phase !== ph)
    begin
      errors++;
      $display("[ERR] phase expected %0d seen %0d", ph, phase);
      final_report();
    end
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    wr_reg(REG_SP0, {4'h0, -5'sd6, 7'd50});
    wr_reg(REG_SP1, {4'h0, -5'sd7, 7'd20});
    foreach (rows[i])
    begin
      leak <= rows[i].r;
      wr_reg(REG_SP_EN, {12'h0, rows[i].en});
      @(posedge mclk);
      #1;
      chk("alarm", alarm, rows[i].a);
      chk("sp state", sp_state, rows[i].s);
      // a segment lights once the value reaches into it
      chk("bar", bar, (50'h1 << ((rows[i].r.mant * BAR_SEGS + MANT_FULL - 1) / MANT_FULL)) - 50'h1);
      chk("expo", expo, rows[i].r.expo);
    end
    done("table");
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk("phase", phase, PH_IDLE);
    chk("reject", {reject, irq}, 2'b00);
    rd_reg(REG_CTRL, 16'h0002);
    rd_reg(REG_ROUGH_T, ROUGH_T_RST);
    rd_reg(REG_SP2, {4'h0, SP_RST});
    rd_reg(4'hf, 16'h0000);
    ce <= 1'b0;
    wr_reg(REG_ROUGH_T, 16'h0001);
    ce <= 1'b1;
    rd_reg(REG_ROUGH_T, ROUGH_T_RST);
    done("reset");
    wr_reg(REG_SP0, {4'h0, -5'sd6, 7'd50});
    wr_reg(REG_SP_EN, 16'h0001);
    wr_reg(REG_IRQ_MASK, 16'h000f);
    wr_reg(REG_XFER_COARSE, 16'h0a01);
    rd_reg(REG_XFER_COARSE, XFER_COARSE_RST);
    chk("irq", irq, 1'b1);
    rd_reg(REG_IRQ_STAT, 16'h0008);
    chk("irq", irq, 1'b0);
    wr_reg(REG_XFER_COARSE, XFER_COARSE_LIMIT);
    rd_reg(REG_XFER_COARSE, XFER_COARSE_LIMIT);
    wr_reg(REG_XFER_COARSE, XFER_COARSE_RST);
    wr_reg(REG_IRQ_MASK, 16'h0000);
    wr_reg(REG_XFER_FINE, 16'h0121);
    rd_reg(REG_XFER_FINE, XFER_FINE_RST);
    chk("irq", irq, 1'b0);
    rd_reg(REG_IRQ_STAT, 16'h0008);
    wr_reg(REG_IRQ_MASK, 16'h000f);
    done("refusal");
    wr_reg(REG_CTRL, 16'h0001);
    leak <= '{-5'sd7, 7'd30};
    push(3'b100);
    wait_ph(PH_COARSE, 120);
    wait_ph(PH_VENT, 120);
    chk("test time", n >= TEST_T_RST * TICKS, 1'b1);
    chk("precise", seen, 1'b0);
    rd_reg(REG_RESULT, {4'h0, -5'sd7, 7'd30});
    leak <= '{-5'sd6, 7'd10};
    rd_reg(REG_RESULT, {4'h0, -5'sd7, 7'd30});
    rd_reg(REG_IRQ_STAT, 16'h0001);
    done("pass");
    wr_reg(REG_CTRL, 16'h0003);
    leak <= '{-5'sd7, 7'd30};
    push(3'b100);
    wait_ph(PH_PRECISE, 120);
    leak <= '{-5'sd6, 7'd90};
    wait_ph(PH_HOLD, 120);
    chk("reject", {reject, sp_out}, 2'b11);
    rd_reg(REG_IRQ_STAT, 16'h0002);
    rd_reg(REG_RESULT, {4'h0, -5'sd6, 7'd90});
    push(3'b100);
    push(3'b001);
    #1;
    chk("phase", phase, PH_HOLD);
    push(3'b010);
    #1;
    chk("phase", phase, PH_VENT);
    leak <= '{-5'sd6, 7'd90};
    seen = 0;
    push(3'b100);
    wait_ph(PH_COARSE, 120);
    wait_ph(PH_HOLD, 120);
    chk("coarse leak", {seen, n >= TEST_T_RST * TICKS}, 2'b01);
    rd_reg(REG_IRQ_STAT, 16'h0002);
    push(3'b010);
    done("fail");
    wr_reg(REG_CTRL, 16'h0001);
    slow <= 1'b1;
    push(3'b100);
    wait_ph(PH_ROUGH, 4);
    wait_ph(PH_HOLD, 120);
    chk("rough time", n >= ROUGH_T_RST * TICKS - 2, 1'b1);
    rd_reg(REG_IRQ_STAT, 16'h0004);
    slow <= 1'b0;
    push(3'b010);
    done("abort");
    // a reset clears the latched result, so the outputs follow the live rate
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    for (int m = 1; m < 3; m++)
    begin
      wr_reg(REG_CTRL, 16'(m << 2));
      leak <= '{-5'sd7, 7'd10};
      repeat (2) @(posedge mclk);
      #1;
      ana0 = analog;
      tone0 = tone;
      @(posedge mclk);
      leak <= '{-5'sd6, 7'd10};
      @(posedge mclk);
      #1;
      chk("analog", analog - ana0, m == 1 ? LOG2_STEP : LOG3_STEP);
      chk("tone", tone > tone0, 1'b1);
    end
    done("analog");
    final_report();
  end
endmodule
`default_nettype wire
